// ===== design/sbcom_map.svh
// register offsets, field positions, codes and timing counts of the mode controller
`ifndef SBCOM_MAP_SVH
`define SBCOM_MAP_SVH
`define SBCOM_ADDR_MODE 7'h01
`define SBCOM_ADDR_MAIN_STAT 7'h03
`define SBCOM_ADDR_WDOG_STAT 7'h05
`define SBCOM_ADDR_EVT_STAT 7'h61
`define SBCOM_ADDR_WAKE_CFG 7'h4c
`define SBCOM_ADDR_IDENT 7'h7e
`define SBCOM_ADDR_NV_CFG 7'h74
`define SBCOM_MC_SLEEP 3'h1
`define SBCOM_MC_STANDBY 3'h4
`define SBCOM_MC_NORMAL 3'h7
`define SBCOM_NV_FNMS_BIT 0
`define SBCOM_NV_SLPL_BIT 1
`define SBCOM_NV_RESET 8'h01
`define SBCOM_RSS_POWER_ON 5'h00
`define SBCOM_RSS_CAN_WAKE 5'h01
`define SBCOM_RSS_PIN_WAKE 5'h04
`define SBCOM_RSS_DIAG_WAKE 5'h0d
`define SBCOM_RSS_EXT_RESET 5'h11
`define SBCOM_RSS_WDOG 5'h0f
`define SBCOM_RSS_V1_UNDERV 5'h12
`define SBCOM_RSS_BAD_SLEEP 5'h14
`define SBCOM_RSS_SPI_FAIL 5'h15
`define SBCOM_RESET_NS 20000
`define SBCOM_CLK_NS 8
`define SBCOM_RESET_CYC ((`SBCOM_RESET_NS + `SBCOM_CLK_NS - 1) / `SBCOM_CLK_NS)
`define SBCOM_STARTUP_NS 2000
`define SBCOM_STARTUP_CYC ((`SBCOM_STARTUP_NS + `SBCOM_CLK_NS - 1) / `SBCOM_CLK_NS)
`define SBCOM_UVD_NS 400
`define SBCOM_UVD_CYC (`SBCOM_UVD_NS / `SBCOM_CLK_NS)
`define SBCOM_IDENT_VAL 8'h5a
`endif

// ===== design/sbcom_pkg.sv
// types of the operating mode controller
package sbcom_pkg;
   typedef enum logic [2:0] {
      SBCOM_OFF, SBCOM_RESET, SBCOM_STANDBY, SBCOM_NORMAL,
      SBCOM_SLEEP, SBCOM_OVERTEMP, SBCOM_FORCED
   } sbcom_mode_t;
   typedef struct packed {
      sbcom_mode_t mode;
      logic [2:0] mc;
      logic [4:0] reset_source_code;
      logic nms;
      logic otw_event;
      logic otw_en;
      logic can_wake_enable;
      logic pne;
      logic partial_net_config_valid;
      logic pin_wake_en;
      logic [7:0] nv;
      logic factory;
      logic uv_hold;
      logic spi_fail;
      logic wake_pend;
      logic [15:0] cnt;
      logic [7:0] rdata;
      logic rvalid;
   } sbcom_state_t;
endpackage

// ===== design/sbcom_ctrl.sv
// operating mode controller of the CAN system basis chip
// Functional notes
// - Standby plus Normal code written: go to Normal, supply and all functions on.
// - Normal plus Standby code written: go to Standby.
// - Standby: transceiver offline, SPI and supply on, watchdog timeout if enabled.
// - CAN wake enabled: selective detection if both partial-net bits set, else pattern.
// - Any enabled wake-up, regular or diagnostic, outside Off and Overtemp forces receive output low while the receiver is off.
// - Power-on, overtemp release and sleep wake-up all go via Reset to Standby, or to Forced Normal if selected.
// - Sleep: supply, SPI, watchdog off; leave only on enabled or diagnostic wake, or on battery low.
// - Sleep command needs no pending wake and one wake source, else Reset illegal.
// - Sleep lockout set: sleep command becomes SPI failure, no Sleep.
// - Reset: reset line low for set time, SPI watchdog off, transmitter off unless Forced Normal selected, supply on.
// - Any reset event from Standby, Normal or Forced Normal enters Reset and records its source.
// - Reset exits to Standby on line release, Forced Normal if selected, Off, Overtemp.
// - Reset caused by supply undervoltage holds until the supply recovers.
// - Battery low gives Off; battery rise enters Reset after startup time.
// - Overtemperature gives Overtemp at once except from Off and Sleep.
// - Warning sets status bit; event captured only when its enable set.
// - Overtemp: CAN off, no new wake, pending wake held, supply off, reset low later.
// - Overtemp exits to Reset on temperature release or to Off on battery low.
// - Forced Normal: watchdog off, supply, aux output and transceiver on.
// - Forced normal select held at 74h, preset 1, boots Forced Normal until cleared.
// - Forced Normal reset keeps transmitter on unless undervoltage; returns to Forced.
// - Forced Normal reads only main and watchdog status, ident and nonvolatile; nv write only factory.
// - Mode select field is bits 2:0 of register 0x01, upper bits read zero.
`timescale 1ns/1ps
`include "sbcom_map.svh"
module sbcom_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // analog monitors
   input wire logic bat_pon,
   input wire logic bat_poff,
   input wire logic temp_otp,
   input wire logic temp_rel,
   input wire logic temp_warn,
   input wire logic v1_uv,
   // wake and reset sources
   input wire logic can_wake,
   input wire logic pin_wake,
   input wire logic wdog_reset,
   input wire logic wdog_enabled,
   input wire logic can_rx_bit,
   // reset line, open drain
   input wire logic reset_line_n_in,
   output logic reset_line_n_out,
   output logic reset_line_n_oe,
   // register access port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // function controls
   output logic mcu_supply,
   output logic aux_supply_output,
   output logic spi_enable,
   output logic wdog_run,
   output logic wdog_timeout_only,
   output logic can_tx_en,
   output logic can_rx_en,
   output logic can_pins_engaged,
   output logic selective_wake,
   output logic rx_out,
   output logic spi_fail_event,
   output sbcom_pkg::sbcom_mode_t mode
);
   sbcom_pkg::sbcom_state_t s_q, s_d;
   logic reg_wake_any;
   logic otp_allowed;
   logic can_wake_en_hit;
   logic sleep_ok;
   logic ext_reset;
   logic read_allowed;
   logic cnt_done;

   // diagnostic wake counts as wake only where detection runs
   assign can_wake_en_hit = s_q.can_wake_enable && can_wake;
   assign reg_wake_any = can_wake_en_hit || (s_q.pin_wake_en && pin_wake);
   assign otp_allowed = s_q.mode != sbcom_pkg::SBCOM_OFF
      && s_q.mode != sbcom_pkg::SBCOM_SLEEP;
   assign sleep_ok = !s_q.wake_pend && !reg_wake_any
      && (s_q.can_wake_enable || s_q.pin_wake_en);
   assign ext_reset = !reset_line_n_in && reset_line_n_out;
   assign cnt_done = s_q.cnt == 16'h0000;
   assign read_allowed = s_q.mode != sbcom_pkg::SBCOM_FORCED
      || reg_addr == `SBCOM_ADDR_MAIN_STAT || reg_addr == `SBCOM_ADDR_WDOG_STAT
      || reg_addr == `SBCOM_ADDR_IDENT || reg_addr == `SBCOM_ADDR_NV_CFG;

   always_comb
   begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.spi_fail = 1'b0;
      if (s_q.cnt != 16'h0000)
      begin
         s_d.cnt = s_q.cnt - 16'h0001;
      end
      if (temp_warn && s_q.otw_en)
      begin
         s_d.otw_event = 1'b1;
      end
      if (s_q.mode != sbcom_pkg::SBCOM_OVERTEMP && s_q.mode != sbcom_pkg::SBCOM_OFF
         && (reg_wake_any || (temp_warn && s_q.otw_en)))
      begin
         s_d.wake_pend = 1'b1;
      end
      // register writes; spi is dead outside the active modes
      if (reg_wr && spi_enable)
      begin
         case (reg_addr)
            `SBCOM_ADDR_MODE:
            begin
               if (s_q.mode != sbcom_pkg::SBCOM_FORCED)
               begin
                  s_d.mc = reg_wdata[2:0];
               end
            end
            `SBCOM_ADDR_EVT_STAT:
            begin
               // set wins for the warning event and for enabled wakes; a warning-only wake set loses to the clear
               if (reg_wdata[0] && !(temp_warn && s_q.otw_en))
               begin
                  s_d.otw_event = 1'b0;
               end
               if (reg_wdata[1] && !reg_wake_any)
               begin
                  s_d.wake_pend = 1'b0;
               end
            end
            `SBCOM_ADDR_WAKE_CFG:
            begin
               s_d.can_wake_enable = reg_wdata[0];
               s_d.pne = reg_wdata[1];
               s_d.partial_net_config_valid = reg_wdata[2];
               s_d.pin_wake_en = reg_wdata[3];
               s_d.otw_en = reg_wdata[4];
            end
            `SBCOM_ADDR_NV_CFG:
            begin
               if (s_q.mode != sbcom_pkg::SBCOM_FORCED || s_q.factory)
               begin
                  s_d.nv = reg_wdata;
                  s_d.factory = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      if (reg_rd && spi_enable)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata = 8'h00;
         if (read_allowed)
         begin
            case (reg_addr)
               `SBCOM_ADDR_MODE: s_d.rdata = {5'h00, s_q.mc};
               `SBCOM_ADDR_MAIN_STAT: s_d.rdata = {1'b0, temp_warn, s_q.nms, s_q.reset_source_code};
               `SBCOM_ADDR_EVT_STAT: s_d.rdata = {6'h00, s_q.wake_pend, s_q.otw_event};
               `SBCOM_ADDR_WAKE_CFG: s_d.rdata = {3'h0, s_q.otw_en, s_q.pin_wake_en,
                  s_q.partial_net_config_valid, s_q.pne, s_q.can_wake_enable};
               `SBCOM_ADDR_NV_CFG: s_d.rdata = s_q.nv;
               `SBCOM_ADDR_IDENT: s_d.rdata = `SBCOM_IDENT_VAL;
               default: s_d.rdata = 8'h00;
            endcase
         end
      end
      // mode sequencing
      case (s_q.mode)
         sbcom_pkg::SBCOM_OFF:
         begin
            if (!bat_pon)
            begin
               s_d.cnt = 16'(`SBCOM_STARTUP_CYC);
            end
            else if (cnt_done)
            begin
               s_d.mode = sbcom_pkg::SBCOM_RESET;
               s_d.reset_source_code = `SBCOM_RSS_POWER_ON;
               s_d.nms = 1'b1;
               s_d.cnt = 16'(`SBCOM_RESET_CYC);
            end
         end
         sbcom_pkg::SBCOM_RESET:
         begin
            if (!v1_uv)
            begin
               s_d.uv_hold = 1'b0;
            end
            if (cnt_done && !s_q.uv_hold && !v1_uv && reset_line_n_in)
            begin
               s_d.mode = s_q.nv[`SBCOM_NV_FNMS_BIT] ? sbcom_pkg::SBCOM_FORCED
                  : sbcom_pkg::SBCOM_STANDBY;
               s_d.mc = `SBCOM_MC_STANDBY;
            end
         end
         sbcom_pkg::SBCOM_STANDBY, sbcom_pkg::SBCOM_NORMAL:
         begin
            if (s_q.mode == sbcom_pkg::SBCOM_STANDBY && s_d.mc == `SBCOM_MC_NORMAL)
            begin
               s_d.mode = sbcom_pkg::SBCOM_NORMAL;
               s_d.nms = 1'b0;
            end
            else if (s_q.mode == sbcom_pkg::SBCOM_NORMAL && s_d.mc == `SBCOM_MC_STANDBY)
            begin
               s_d.mode = sbcom_pkg::SBCOM_STANDBY;
            end
            else if (s_d.mc == `SBCOM_MC_SLEEP && s_q.mc != `SBCOM_MC_SLEEP)
            begin
               if (s_q.nv[`SBCOM_NV_SLPL_BIT])
               begin
                  s_d.spi_fail = 1'b1;
                  s_d.mc = s_q.mc;
                  s_d.mode = sbcom_pkg::SBCOM_RESET;
                  s_d.reset_source_code = `SBCOM_RSS_SPI_FAIL;
                  s_d.cnt = 16'(`SBCOM_RESET_CYC);
               end
               else if (sleep_ok)
               begin
                  s_d.mode = sbcom_pkg::SBCOM_SLEEP;
               end
               else
               begin
                  s_d.mode = sbcom_pkg::SBCOM_RESET;
                  s_d.reset_source_code = `SBCOM_RSS_BAD_SLEEP;
                  s_d.cnt = 16'(`SBCOM_RESET_CYC);
               end
            end
         end
         sbcom_pkg::SBCOM_SLEEP:
         begin
            if (reg_wake_any || (temp_warn && s_q.otw_en))
            begin
               s_d.mode = sbcom_pkg::SBCOM_RESET;
               s_d.reset_source_code = can_wake_en_hit ? `SBCOM_RSS_CAN_WAKE
                  : (reg_wake_any ? `SBCOM_RSS_PIN_WAKE : `SBCOM_RSS_DIAG_WAKE);
               s_d.cnt = 16'(`SBCOM_RESET_CYC);
            end
         end
         sbcom_pkg::SBCOM_OVERTEMP:
         begin
            if (temp_rel)
            begin
               s_d.mode = sbcom_pkg::SBCOM_RESET;
               s_d.cnt = 16'(`SBCOM_RESET_CYC);
            end
         end
         sbcom_pkg::SBCOM_FORCED:
         begin
         end
         default:
         begin
            s_d.mode = sbcom_pkg::SBCOM_OFF;
         end
      endcase
      // reset events from active modes
      if (s_q.mode == sbcom_pkg::SBCOM_STANDBY || s_q.mode == sbcom_pkg::SBCOM_NORMAL
         || s_q.mode == sbcom_pkg::SBCOM_FORCED)
      begin
         if (v1_uv || ext_reset || wdog_reset)
         begin
            s_d.mode = sbcom_pkg::SBCOM_RESET;
            s_d.reset_source_code = v1_uv ? `SBCOM_RSS_V1_UNDERV
               : (ext_reset ? `SBCOM_RSS_EXT_RESET : `SBCOM_RSS_WDOG);
            s_d.uv_hold = v1_uv;
            s_d.cnt = 16'(`SBCOM_RESET_CYC);
         end
      end
      if (temp_otp && otp_allowed)
      begin
         if (s_q.mode != sbcom_pkg::SBCOM_OVERTEMP)
         begin
            s_d.cnt = 16'(`SBCOM_UVD_CYC);
         end
         s_d.mode = sbcom_pkg::SBCOM_OVERTEMP;
      end
      if (bat_poff && s_q.mode != sbcom_pkg::SBCOM_OFF)
      begin
         s_d.mode = sbcom_pkg::SBCOM_OFF;
         s_d.cnt = 16'(`SBCOM_STARTUP_CYC);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_q <= '0;
         s_q.mode <= sbcom_pkg::SBCOM_OFF;
         s_q.mc <= `SBCOM_MC_STANDBY;
         s_q.nv <= `SBCOM_NV_RESET;
         s_q.factory <= 1'b1;
         s_q.nms <= 1'b1;
         s_q.cnt <= 16'(`SBCOM_STARTUP_CYC);
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // function gating per mode
   always_comb
   begin
      mode = s_q.mode;
      mcu_supply = 1'b0;
      aux_supply_output = 1'b0;
      spi_enable = 1'b0;
      wdog_run = 1'b0;
      wdog_timeout_only = 1'b0;
      can_tx_en = 1'b0;
      can_rx_en = 1'b0;
      can_pins_engaged = 1'b1;
      reset_line_n_out = 1'b0;
      case (s_q.mode)
         sbcom_pkg::SBCOM_OFF: can_pins_engaged = 1'b0;
         sbcom_pkg::SBCOM_RESET:
         begin
            mcu_supply = 1'b1;
            can_tx_en = s_q.nv[`SBCOM_NV_FNMS_BIT] && !s_q.uv_hold;
            // pin let go once the low time is served and the supply is good
            reset_line_n_out = cnt_done && !s_q.uv_hold && !v1_uv;
         end
         sbcom_pkg::SBCOM_STANDBY:
         begin
            mcu_supply = 1'b1;
            spi_enable = 1'b1;
            wdog_run = wdog_enabled;
            wdog_timeout_only = 1'b1;
            reset_line_n_out = 1'b1;
         end
         sbcom_pkg::SBCOM_NORMAL:
         begin
            mcu_supply = 1'b1;
            aux_supply_output = 1'b1;
            spi_enable = 1'b1;
            wdog_run = wdog_enabled;
            can_tx_en = 1'b1;
            can_rx_en = 1'b1;
            reset_line_n_out = 1'b1;
         end
         sbcom_pkg::SBCOM_FORCED:
         begin
            mcu_supply = 1'b1;
            aux_supply_output = 1'b1;
            spi_enable = 1'b1;
            can_tx_en = 1'b1;
            can_rx_en = 1'b1;
            reset_line_n_out = 1'b1;
         end
         sbcom_pkg::SBCOM_OVERTEMP:
         begin
            // supply cut at once; reset line follows after the undervoltage delay
            mcu_supply = 1'b0;
            reset_line_n_out = !cnt_done;
            can_pins_engaged = 1'b0;
         end
         default:
         begin
         end
      endcase
   end

   // reset line is open drain; the low counts off the defined time in reset
   assign reset_line_n_oe = !reset_line_n_out;
   assign selective_wake = s_q.can_wake_enable && s_q.pne && s_q.partial_net_config_valid;
   assign rx_out = can_rx_en ? can_rx_bit : !s_q.wake_pend;
   assign spi_fail_event = s_q.spi_fail;
   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;

   a_normal_entry: assert property (@(posedge clk) disable iff (srst)
      s_q.mode == sbcom_pkg::SBCOM_STANDBY && reg_wr && reg_addr == `SBCOM_ADDR_MODE
      && reg_wdata[2:0] == `SBCOM_MC_NORMAL && !v1_uv && !ext_reset && !wdog_reset
      && !temp_otp && !bat_poff |=> mode == sbcom_pkg::SBCOM_NORMAL && mcu_supply)
      else $error("normal not entered");
   a_standby_entry: assert property (@(posedge clk) disable iff (srst)
      s_q.mode == sbcom_pkg::SBCOM_NORMAL && reg_wr && reg_addr == `SBCOM_ADDR_MODE
      && reg_wdata[2:0] == `SBCOM_MC_STANDBY && !v1_uv && !ext_reset && !wdog_reset
      && !temp_otp && !bat_poff |=> mode == sbcom_pkg::SBCOM_STANDBY)
      else $error("standby not entered");
   a_standby_gating: assert property (@(posedge clk) disable iff (srst)
      mode == sbcom_pkg::SBCOM_STANDBY |-> !can_tx_en && spi_enable && mcu_supply)
      else $error("standby gating wrong");
   a_sleep_gating: assert property (@(posedge clk) disable iff (srst)
      mode == sbcom_pkg::SBCOM_SLEEP |-> !mcu_supply && !spi_enable && !wdog_run)
      else $error("sleep gating wrong");
   a_bad_sleep: assert property (@(posedge clk) disable iff (srst)
      s_q.mode == sbcom_pkg::SBCOM_STANDBY && s_d.mc == `SBCOM_MC_SLEEP && !sleep_ok
      && !s_q.nv[`SBCOM_NV_SLPL_BIT] && !temp_otp && !bat_poff && !v1_uv && !ext_reset
      && !wdog_reset |=> mode == sbcom_pkg::SBCOM_RESET && s_q.reset_source_code == `SBCOM_RSS_BAD_SLEEP)
      else $error("illegal sleep not caught");
   a_reset_low: assert property (@(posedge clk) disable iff (srst)
      $rose(mode == sbcom_pkg::SBCOM_RESET) |-> !reset_line_n_out [*8])
      else $error("reset line released early");
   a_otp_entry: assert property (@(posedge clk) disable iff (srst)
      temp_otp && otp_allowed && !bat_poff |=> mode == sbcom_pkg::SBCOM_OVERTEMP)
      else $error("overtemp not entered");
   a_forced_wdog: assert property (@(posedge clk) disable iff (srst)
      mode == sbcom_pkg::SBCOM_FORCED |-> !wdog_run && can_tx_en && aux_supply_output)
      else $error("forced normal gating wrong");
   c_reach_normal: cover property (@(posedge clk) mode == sbcom_pkg::SBCOM_NORMAL);
   c_reach_sleep: cover property (@(posedge clk) mode == sbcom_pkg::SBCOM_SLEEP);
   c_reach_forced: cover property (@(posedge clk) mode == sbcom_pkg::SBCOM_FORCED);
endmodule

// ===== bench/sbcom_mcu_model.sv
// microcontroller side of the reset pin: pull-up, external pull and spi wait after release
`timescale 1ns/1ps
module sbcom_mcu_model #(
   parameter int SPI_TO_CYC = 32
) (
   // clock
   input wire logic clk,
   // device side of the open-drain pin
   input wire logic reset_line_n_oe,
   // host side
   input wire logic pull_low,
   output logic reset_line_n_in,
   output logic spi_ready
);
   int cnt = 0;
   // pulled up: low only while one of the parties pulls
   assign reset_line_n_in = !(reset_line_n_oe || pull_low);
   // host keeps off the spi until the timeout after the rising edge has run out
   always @(posedge clk)
   begin
      if (!reset_line_n_in)
         cnt <= 0;
      else if (cnt < SPI_TO_CYC)
         cnt <= cnt + 1;
   end
   assign spi_ready = (cnt == SPI_TO_CYC);
endmodule

// ===== bench/tb.sv
// self-checking bench of the operating mode controller
`timescale 1ns/1ps
`include "sbcom_map.svh"
module tb;
   logic clk = 1'b0;
   logic srst, bat_pon, bat_poff, temp_otp, temp_rel, temp_warn, v1_uv;
   logic can_wake, pin_wake, wdog_reset, wdog_enabled, can_rx_bit, pull_low;
   logic reset_line_n_in, reset_line_n_oe, spi_ready;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic mcu_supply, aux_supply_output, spi_enable, wdog_run, wdog_timeout_only;
   logic can_tx_en, can_rx_en, can_pins_engaged, selective_wake, rx_out, spi_fail_event;
   sbcom_pkg::sbcom_mode_t mode;
   int err_count = 0;
   int num_checks = 0;

   always #4 clk = ~clk;

   sbcom_ctrl sbcom_ctrl_i (.clk(clk), .srst(srst), .bat_pon(bat_pon), .bat_poff(bat_poff),
      .temp_otp(temp_otp), .temp_rel(temp_rel), .temp_warn(temp_warn), .v1_uv(v1_uv),
      .can_wake(can_wake), .pin_wake(pin_wake), .wdog_reset(wdog_reset),
      .wdog_enabled(wdog_enabled), .can_rx_bit(can_rx_bit), .reset_line_n_in(reset_line_n_in),
      .reset_line_n_out(), .reset_line_n_oe(reset_line_n_oe), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .mcu_supply(mcu_supply), .aux_supply_output(aux_supply_output),
      .spi_enable(spi_enable), .wdog_run(wdog_run), .wdog_timeout_only(wdog_timeout_only),
      .can_tx_en(can_tx_en), .can_rx_en(can_rx_en), .can_pins_engaged(can_pins_engaged),
      .selective_wake(selective_wake), .rx_out(rx_out), .spi_fail_event(spi_fail_event),
      .mode(mode));

   sbcom_mcu_model sbcom_mcu_model_i (.clk(clk), .reset_line_n_oe(reset_line_n_oe),
      .pull_low(pull_low), .reset_line_n_in(reset_line_n_in), .spi_ready(spi_ready));

   task end_sim;
      begin
         if (err_count == 0 && num_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   task check(input logic [7:0] seen, input logic [7:0] exp);
      begin
         num_checks++;
         if (seen !== exp)
         begin
            err_count++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask

   // all access tasks start and end at a falling edge
   task wr(input logic [6:0] a, input logic [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         @(negedge clk);
         reg_wr = 1'b0;
         @(negedge clk);
      end
   endtask

   task rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] exp);
      begin
         reg_addr = a;
         reg_rd = 1'b1;
         @(negedge clk);
         reg_rd = 1'b0;
         check({7'h00, reg_rvalid}, 8'h01);
         check(reg_rdata & m, exp);
         @(negedge clk);
      end
   endtask

   task chk_mode(input sbcom_pkg::sbcom_mode_t m, input int lim);
      int i;
      begin
         i = 0;
         while (mode !== m && i < lim)
         begin
            @(negedge clk);
            i++;
         end
         check({5'h00, mode}, {5'h00, m});
      end
   endtask

   task wait_spi;
      int i;
      begin
         i = 0;
         while (spi_ready !== 1'b1 && i < 100)
         begin
            @(negedge clk);
            i++;
         end
         check({7'h00, spi_ready}, 8'h01);
      end
   endtask

   initial
   begin
      repeat (40000) @(posedge clk);
      err_count++;
      end_sim;
   end

   initial
   begin
      srst = 1'b1;
      {bat_pon, bat_poff, temp_otp, temp_rel, temp_warn, v1_uv} = 6'h00;
      {can_wake, pin_wake, wdog_reset, wdog_enabled, can_rx_bit, pull_low} = 6'h00;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 17'h00000;
      repeat (3) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      chk_mode(sbcom_pkg::SBCOM_OFF, 1);
      bat_pon = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_RESET, 300);
      check({6'h00, reset_line_n_oe, spi_enable}, 8'h02);
      chk_mode(sbcom_pkg::SBCOM_FORCED, 2600);
      wait_spi;
      check({4'h0, wdog_run, mcu_supply, aux_supply_output, can_tx_en}, 8'h07);
      rd(`SBCOM_ADDR_NV_CFG, 8'hff, `SBCOM_NV_RESET);
      rd(`SBCOM_ADDR_IDENT, 8'hff, `SBCOM_IDENT_VAL);
      rd(`SBCOM_ADDR_MODE, 8'hff, 8'h00);
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_NORMAL});
      chk_mode(sbcom_pkg::SBCOM_FORCED, 1);
      // external pull on the reset pin while forced
      pull_low = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_RESET, 5);
      pull_low = 1'b0;
      check({7'h00, can_tx_en}, 8'h01);
      chk_mode(sbcom_pkg::SBCOM_FORCED, 2600);
      wait_spi;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h1f, {3'h0, `SBCOM_RSS_EXT_RESET});
      wr(`SBCOM_ADDR_NV_CFG, 8'h00);
      rd(`SBCOM_ADDR_NV_CFG, 8'h03, 8'h00);
      // supply undervoltage holds reset until recovery
      v1_uv = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_RESET, 5);
      repeat (2700) @(negedge clk);
      chk_mode(sbcom_pkg::SBCOM_RESET, 1);
      v1_uv = 1'b0;
      wdog_enabled = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_STANDBY, 2600);
      wait_spi;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h1f, {3'h0, `SBCOM_RSS_V1_UNDERV});
      check({2'h0, wdog_run, wdog_timeout_only, can_tx_en, can_rx_en, spi_enable,
         mcu_supply}, 8'h33);
      rd(`SBCOM_ADDR_MODE, 8'hf8, 8'h00);
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_NORMAL});
      chk_mode(sbcom_pkg::SBCOM_NORMAL, 1);
      check({7'h00, mcu_supply}, 8'h01);
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_STANDBY});
      chk_mode(sbcom_pkg::SBCOM_STANDBY, 1);
      // sleep with no wake source enabled is illegal
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_SLEEP});
      chk_mode(sbcom_pkg::SBCOM_RESET, 2);
      chk_mode(sbcom_pkg::SBCOM_STANDBY, 2600);
      wait_spi;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h1f, {3'h0, `SBCOM_RSS_BAD_SLEEP});
      wr(`SBCOM_ADDR_WAKE_CFG, 8'h07);
      check({7'h00, selective_wake}, 8'h01);
      wr(`SBCOM_ADDR_WAKE_CFG, 8'h03);
      check({7'h00, selective_wake}, 8'h00);
      wr(`SBCOM_ADDR_WAKE_CFG, 8'h01);
      can_wake = 1'b1;
      @(negedge clk);
      can_wake = 1'b0;
      @(negedge clk);
      check({7'h00, rx_out}, 8'h00);
      wr(`SBCOM_ADDR_EVT_STAT, 8'h02);
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_SLEEP});
      chk_mode(sbcom_pkg::SBCOM_SLEEP, 2);
      check({5'h00, mcu_supply, spi_enable, wdog_run}, 8'h00);
      wr(`SBCOM_ADDR_MODE, {5'h00, `SBCOM_MC_NORMAL});
      chk_mode(sbcom_pkg::SBCOM_SLEEP, 1);
      can_wake = 1'b1;
      @(negedge clk);
      can_wake = 1'b0;
      chk_mode(sbcom_pkg::SBCOM_RESET, 3);
      chk_mode(sbcom_pkg::SBCOM_STANDBY, 2600);
      wait_spi;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h1f, {3'h0, `SBCOM_RSS_CAN_WAKE});
      // sleep lockout turns a sleep command into an spi failure
      wr(`SBCOM_ADDR_NV_CFG, 8'h02);
      reg_addr = `SBCOM_ADDR_MODE;
      reg_wdata = {5'h00, `SBCOM_MC_SLEEP};
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      check({7'h00, spi_fail_event}, 8'h01);
      chk_mode(sbcom_pkg::SBCOM_RESET, 1);
      chk_mode(sbcom_pkg::SBCOM_STANDBY, 2600);
      wait_spi;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h1f, {3'h0, `SBCOM_RSS_SPI_FAIL});
      temp_warn = 1'b1;
      rd(`SBCOM_ADDR_MAIN_STAT, 8'h40, 8'h40);
      rd(`SBCOM_ADDR_EVT_STAT, 8'h01, 8'h00);
      wr(`SBCOM_ADDR_WAKE_CFG, 8'h11);
      rd(`SBCOM_ADDR_EVT_STAT, 8'h01, 8'h01);
      temp_warn = 1'b0;
      temp_otp = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_OVERTEMP, 2);
      check({4'h0, can_tx_en, can_rx_en, mcu_supply, reset_line_n_oe}, 8'h00);
      check({7'h00, rx_out}, 8'h00);
      repeat (60) @(negedge clk);
      check({7'h00, reset_line_n_oe}, 8'h01);
      temp_otp = 1'b0;
      temp_rel = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_RESET, 3);
      bat_pon = 1'b0;
      bat_poff = 1'b1;
      chk_mode(sbcom_pkg::SBCOM_OFF, 3);
      check({7'h00, can_pins_engaged}, 8'h00);
      end_sim;
   end
endmodule
